// File: swu_dev.sv
// Device end: autobaud single-wire UART slave with CRC8 register access
`timescale 1ns/1ps
module swu_dev #(
  parameter int BIT_DEF = swu_pkg::DEF_BIT_CYC,
  parameter int CW = 24
) (
  input wire logic clk_i,
  input wire logic srst_i,
  swu_if.dev link,
  input wire logic [3:0] reply_turnaround_delay_i,
  input wire logic [31:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic [6:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  output logic [7:0] write_count_o,
  output logic rx_error_o
);
  swu_pkg::swu_dev_state_e state;
  logic rx;
  logic rx_q;
  logic [CW-1:0] cnt;
  logic [CW-1:0] gap;
  logic [CW-1:0] bit_cyc;
  logic [CW-1:0] good_bit;
  logic [1:0] nfall;
  logic seen_rise;
  logic [3:0] idx;
  logic [7:0] sh;
  logic [2:0] nbyte;
  logic [7:0] crc;
  logic is_wr;
  logic [6:0] addr;
  logic [31:0] data;
  logic [9:0] txf;
  logic [7:0] next_tx_byte;
  logic [2:0] tx_sel;
  logic [7:0] next_crc;
  logic fall;
  logic rise;

  // Both lines are inputs; the true line carries the data
  assign rx = link.serial_line_true;
  assign fall = rx_q & ~rx;
  assign rise = ~rx_q & rx;
  assign next_crc = swu_pkg::swu_crc8(crc, sh);
  // First load takes byte 0, later loads the byte after the one sent
  assign tx_sel = (idx == 4'h0) ? nbyte : nbyte + 3'h1;

  // Reply bytes; data taken live, no snapshot
  always_comb begin
    unique case (tx_sel)
      3'h0: next_tx_byte = swu_pkg::SYNC_BYTE;
      3'h1: next_tx_byte = {1'b0, addr};
      3'h2: next_tx_byte = reg_rdata_i[31:24];
      3'h3: next_tx_byte = reg_rdata_i[23:16];
      3'h4: next_tx_byte = reg_rdata_i[15:8];
      3'h5: next_tx_byte = reg_rdata_i[7:0];
      default: next_tx_byte = crc;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_q <= 1'b1;
    end else begin
      rx_q <= rx;
    end
  end

  // Time since the last start bit
  always_ff @(posedge clk_i) begin
    if (srst_i || (fall && (state == swu_pkg::ST_IDLE ||
        state == swu_pkg::ST_GAP))) begin
      gap <= '0;
    end else if (gap != '1) begin
      gap <= gap + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= swu_pkg::ST_IDLE;
      cnt <= '0;
      bit_cyc <= CW'(BIT_DEF);
      good_bit <= CW'(BIT_DEF);
      nfall <= '0;
      seen_rise <= 1'b0;
      idx <= '0;
      sh <= '0;
      nbyte <= '0;
      crc <= swu_pkg::CRC_INIT;
      is_wr <= 1'b0;
      addr <= '0;
      data <= '0;
      txf <= '1;
      reg_wr_o <= 1'b0;
      reg_addr_o <= '0;
      reg_wdata_o <= '0;
      write_count_o <= '0;
      rx_error_o <= 1'b0;
    end else begin
      reg_wr_o <= 1'b0;
      rx_error_o <= 1'b0;
      unique case (state)
        swu_pkg::ST_IDLE: begin
          if (fall) begin
            state <= swu_pkg::ST_MEAS;
            cnt <= CW'(1);
            nfall <= '0;
            seen_rise <= 1'b0;
          end
        end
        swu_pkg::ST_MEAS: begin
          cnt <= cnt + 1'b1;
          if (rise && !seen_rise) begin
            seen_rise <= 1'b1;
            if (cnt < CW'(swu_pkg::GLITCH_CYC)) begin
              state <= swu_pkg::ST_RECOV;
              cnt <= '0;
              rx_error_o <= 1'b1;
            end
          end
          if (fall) begin
            nfall <= nfall + 1'b1;
            if (nfall == 2'h1) begin
              // Four bit times measured: start, bit0..bit2
              bit_cyc <= cnt >> 2;
              cnt <= cnt >> 3;
              idx <= 4'h4;
              // Sync bits 0..2 land at the bottom after five shifts
              sh <= {swu_pkg::SYNC_BYTE[2:0], 5'h00};
              nbyte <= '0;
              crc <= swu_pkg::CRC_INIT;
              state <= swu_pkg::ST_BYTE;
            end
          end
          if (cnt[CW-1]) begin
            state <= swu_pkg::ST_RECOV;
            cnt <= '0;
            rx_error_o <= 1'b1;
          end
        end
        swu_pkg::ST_BYTE: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            cnt <= bit_cyc - 1'b1;
            idx <= idx + 1'b1;
            if (idx >= 4'h1 && idx <= 4'h8) begin
              sh <= {rx, sh[7:1]};
            end
            if ((idx == 4'h0 && rx) || (idx == 4'h9 && !rx)) begin
              state <= swu_pkg::ST_RECOV;
              cnt <= '0;
              rx_error_o <= 1'b1;
            end else if (idx == 4'h9) begin
              nbyte <= nbyte + 1'b1;
              crc <= next_crc;
              state <= swu_pkg::ST_GAP;
              if (nbyte == 3'h0 && sh != swu_pkg::SYNC_BYTE) begin
                state <= swu_pkg::ST_RECOV;
                cnt <= '0;
                rx_error_o <= 1'b1;
              end
              if (nbyte == 3'h1) begin
                is_wr <= sh[swu_pkg::WR_BIT];
                addr <= sh[6:0];
              end
              if (nbyte >= 3'h2 && is_wr) begin
                data <= {data[23:0], sh};
              end
              if (nbyte >= 3'h2 && (is_wr ? nbyte == swu_pkg::LAST_WR :
                  nbyte == swu_pkg::LAST_RD)) begin
                if (sh != crc) begin
                  state <= swu_pkg::ST_RECOV;
                  cnt <= '0;
                  rx_error_o <= 1'b1;
                end else if (is_wr) begin
                  good_bit <= bit_cyc;
                  reg_wr_o <= 1'b1;
                  reg_addr_o <= addr;
                  reg_wdata_o <= data;
                  write_count_o <= write_count_o + 1'b1;
                  state <= swu_pkg::ST_IDLE;
                end else begin
                  good_bit <= bit_cyc;
                  state <= swu_pkg::ST_TURN;
                  cnt <= CW'(reply_turnaround_delay_i) *
                         CW'(swu_pkg::TURN_UNIT_BITS) * bit_cyc;
                end
              end
            end
          end
        end
        swu_pkg::ST_GAP: begin
          if (gap > CW'(swu_pkg::GAP_BITS) * good_bit) begin
            state <= swu_pkg::ST_RECOV;
            cnt <= '0;
            rx_error_o <= 1'b1;
          end else if (fall) begin
            state <= swu_pkg::ST_BYTE;
            idx <= '0;
            cnt <= bit_cyc >> 1;
          end
        end
        swu_pkg::ST_TURN: begin
          if (cnt > CW'(1)) begin
            cnt <= cnt - 1'b1;
          end else begin
            state <= swu_pkg::ST_TX;
            nbyte <= '0;
            crc <= swu_pkg::CRC_INIT;
            idx <= '0;
            cnt <= '0;
          end
        end
        swu_pkg::ST_TX: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (idx == 4'h0 && nbyte == 3'h0 && txf == '1 &&
                       crc == swu_pkg::CRC_INIT) begin
            txf <= {1'b1, next_tx_byte, 1'b0};
            crc <= swu_pkg::swu_crc8(crc, next_tx_byte);
            cnt <= bit_cyc - 1'b1;
            idx <= 4'h1;
          end else if (idx != 4'(swu_pkg::FRAME_BITS)) begin
            txf <= {1'b1, txf[9:1]};
            cnt <= bit_cyc - 1'b1;
            idx <= idx + 1'b1;
          end else if (nbyte == swu_pkg::LAST_WR) begin
            state <= swu_pkg::ST_HOLD;
            txf <= '1;
            cnt <= CW'(swu_pkg::HOLD_BITS) * bit_cyc - 1'b1;
          end else begin
            nbyte <= nbyte + 1'b1;
            txf <= {1'b1, next_tx_byte, 1'b0};
            crc <= swu_pkg::swu_crc8(crc, next_tx_byte);
            cnt <= bit_cyc - 1'b1;
            idx <= 4'h1;
          end
        end
        swu_pkg::ST_HOLD: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            state <= swu_pkg::ST_IDLE;
            crc <= swu_pkg::CRC_INIT;
          end
        end
        swu_pkg::ST_RECOV: begin
          if (!rx) begin
            cnt <= '0;
          end else if (cnt >= CW'(swu_pkg::RECOV_BITS) * good_bit) begin
            state <= swu_pkg::ST_IDLE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      endcase
    end
  end

  // Drivers on both lines only while replying
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      link.dev_true <= 1'b1;
      link.dev_inv <= 1'b0;
      link.dev_true_oe <= 1'b0;
      link.dev_inv_oe <= 1'b0;
    end else begin
      link.dev_true <= txf[0];
      link.dev_inv <= ~txf[0];
      link.dev_true_oe <= (state == swu_pkg::ST_TX ||
                           state == swu_pkg::ST_HOLD);
      link.dev_inv_oe <= (state == swu_pkg::ST_TX ||
                          state == swu_pkg::ST_HOLD);
    end
  end
endmodule

// File: swu_pkg.sv
// Shared constants, state codes and CRC helper for the single-wire UART link
package swu_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int MIN_BAUD = 9000;
  localparam int DEF_BIT_CYC = CLK_HZ / MIN_BAUD;
  localparam int HOST_BIT_CYC = 200;
  localparam int GLITCH_CYC = 16;
  localparam int GAP_BITS = 63;
  localparam int RECOV_BITS = 12;
  localparam int HOLD_BITS = 4;
  localparam int TURN_UNIT_BITS = 8;
  localparam int REPLY_WAIT_BITS = 160;
  localparam int FRAME_BITS = 10;
  localparam logic [3:0] TURN_RESET = 4'h1;
  localparam logic [7:0] SYNC_BYTE = 8'h05;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [2:0] LAST_WR = 3'h6;
  localparam logic [2:0] LAST_RD = 3'h2;
  localparam int WR_BIT = 7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MEAS = 3'b001,
    ST_BYTE = 3'b010,
    ST_GAP = 3'b011,
    ST_TURN = 3'b100,
    ST_TX = 3'b101,
    ST_HOLD = 3'b110,
    ST_RECOV = 3'b111
  } swu_dev_state_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_GUARD = 3'b001,
    HS_TX = 3'b010,
    HS_WAIT = 3'b011,
    HS_RX = 3'b100
  } swu_host_state_e;

  // Bit-serial CRC8, data bits fed least significant first
  function automatic logic [7:0] swu_crc8(input logic [7:0] c_in,
                                          input logic [7:0] b);
    logic [7:0] c;
    logic fb;
    c = c_in;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb = c[7] ^ b[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction
endpackage

// File: swu_if.sv
// Shared single wire pair joining the device end and the host end
`timescale 1ns/1ps
interface swu_if;
  logic dev_true;
  logic dev_true_oe;
  logic dev_inv;
  logic dev_inv_oe;
  logic host_tx;
  logic host_oe;
  logic serial_line_true;
  logic serial_line_inverted;

  // True line pulled high when nobody drives; the inverted line then sits low
  assign serial_line_true = dev_true_oe ? dev_true :
                            (host_oe ? host_tx : 1'b1);
  assign serial_line_inverted = dev_inv_oe ? dev_inv : ~serial_line_true;

  modport dev (
    input serial_line_true,
    input serial_line_inverted,
    output dev_true,
    output dev_true_oe,
    output dev_inv,
    output dev_inv_oe
  );

  modport host (
    input serial_line_true,
    output host_tx,
    output host_oe
  );
endinterface

// File: swu_host.sv
// Host end: sends write and read datagrams and collects read replies
`timescale 1ns/1ps
module swu_host #(
  parameter int BIT_CYC = swu_pkg::HOST_BIT_CYC,
  parameter int CW = 24
) (
  input wire logic clk_i,
  input wire logic srst_i,
  swu_if.host link,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [6:0] cmd_addr_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic busy_o,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  output logic rd_error_o
);
  swu_pkg::swu_host_state_e state;
  logic [CW-1:0] cnt;
  logic [3:0] idx;
  logic [2:0] nbyte;
  logic [7:0] crc;
  logic [7:0] sh;
  logic [9:0] txf;
  logic wr;
  logic [6:0] addr;
  logic [31:0] data;
  logic [7:0] next_byte;
  logic bad;
  logic rx_q;
  logic rx;
  logic [2:0] nsel;

  assign rx = link.serial_line_true;
  // Guard loads byte 0, later loads the byte after the one sent
  assign nsel = (state == swu_pkg::HS_GUARD) ? nbyte : nbyte + 3'h1;

  always_comb begin
    unique case (nsel)
      3'h0: next_byte = swu_pkg::SYNC_BYTE;
      3'h1: next_byte = {wr, addr};
      3'h2: next_byte = wr ? data[31:24] : crc;
      3'h3: next_byte = data[23:16];
      3'h4: next_byte = data[15:8];
      3'h5: next_byte = data[7:0];
      default: next_byte = crc;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_q <= 1'b1;
    end else begin
      rx_q <= rx;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= swu_pkg::HS_IDLE;
      cnt <= '0;
      idx <= '0;
      nbyte <= '0;
      crc <= swu_pkg::CRC_INIT;
      sh <= '0;
      txf <= '1;
      wr <= 1'b0;
      addr <= '0;
      data <= '0;
      bad <= 1'b0;
      busy_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
      rd_error_o <= 1'b0;
      link.host_tx <= 1'b1;
      link.host_oe <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      link.host_tx <= txf[0];
      unique case (state)
        swu_pkg::HS_IDLE: begin
          busy_o <= 1'b0;
          link.host_oe <= 1'b0;
          if (cmd_valid_i) begin
            busy_o <= 1'b1;
            wr <= cmd_write_i;
            addr <= cmd_addr_i;
            data <= cmd_wdata_i;
            crc <= swu_pkg::CRC_INIT;
            nbyte <= '0;
            // Idle line ahead of every datagram
            cnt <= CW'(swu_pkg::RECOV_BITS * BIT_CYC);
            state <= swu_pkg::HS_GUARD;
          end
        end
        swu_pkg::HS_GUARD: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            link.host_oe <= 1'b1;
            txf <= {1'b1, next_byte, 1'b0};
            crc <= swu_pkg::swu_crc8(crc, next_byte);
            cnt <= CW'(BIT_CYC - 1);
            idx <= 4'h1;
            state <= swu_pkg::HS_TX;
          end
        end
        swu_pkg::HS_TX: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (idx != 4'(swu_pkg::FRAME_BITS)) begin
            txf <= {1'b1, txf[9:1]};
            cnt <= CW'(BIT_CYC - 1);
            idx <= idx + 1'b1;
          end else if (nbyte == (wr ? swu_pkg::LAST_WR :
                       swu_pkg::LAST_RD)) begin
            link.host_oe <= 1'b0;
            txf <= '1;
            nbyte <= '0;
            crc <= swu_pkg::CRC_INIT;
            bad <= 1'b0;
            cnt <= CW'(swu_pkg::REPLY_WAIT_BITS * BIT_CYC);
            state <= wr ? swu_pkg::HS_IDLE : swu_pkg::HS_WAIT;
          end else begin
            nbyte <= nbyte + 1'b1;
            txf <= {1'b1, next_byte, 1'b0};
            crc <= swu_pkg::swu_crc8(crc, next_byte);
            cnt <= CW'(BIT_CYC - 1);
            idx <= 4'h1;
          end
        end
        swu_pkg::HS_WAIT: begin
          if (rx_q && !rx) begin
            state <= swu_pkg::HS_RX;
            cnt <= CW'(BIT_CYC / 2);
            idx <= '0;
          end else if (cnt == '0) begin
            rd_valid_o <= 1'b1;
            rd_error_o <= 1'b1;
            state <= swu_pkg::HS_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        swu_pkg::HS_RX: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (idx != 4'h9) begin
            if (idx != 4'h0) begin
              sh <= {rx, sh[7:1]};
            end
            cnt <= CW'(BIT_CYC - 1);
            idx <= idx + 1'b1;
          end else begin
            nbyte <= nbyte + 1'b1;
            crc <= swu_pkg::swu_crc8(crc, sh);
            if ((nbyte == 3'h0 && sh != swu_pkg::SYNC_BYTE) ||
                (nbyte == 3'h1 && sh != {1'b0, addr}) || !rx) begin
              bad <= 1'b1;
            end
            if (nbyte >= 3'h2 && nbyte <= 3'h5) begin
              rd_data_o <= {rd_data_o[23:0], sh};
            end
            if (nbyte == swu_pkg::LAST_WR) begin
              rd_valid_o <= 1'b1;
              rd_error_o <= bad || (sh != crc);
              state <= swu_pkg::HS_IDLE;
            end else begin
              cnt <= CW'(swu_pkg::REPLY_WAIT_BITS * BIT_CYC);
              state <= swu_pkg::HS_WAIT;
            end
          end
        end
        default: state <= swu_pkg::HS_IDLE;
      endcase
    end
  end
endmodule

// File: swu_link_checker.sv
// Protocol assertions on the shared single wire pair
`timescale 1ns/1ps
module swu_link_checker #(
  parameter int BIT = 32
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic dev_true,
  input wire logic dev_true_oe,
  input wire logic dev_inv,
  input wire logic dev_inv_oe,
  input wire logic host_tx,
  input wire logic host_oe,
  input wire logic serial_line_true,
  input wire logic serial_line_inverted
);
  int run;
  logic last;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // Length of the present level while the device drives
  always_ff @(posedge clk_i) begin
    if (srst_i || !dev_true_oe) begin
      run <= 0;
    end else if (dev_true != last) begin
      run <= 1;
    end else begin
      run <= run + 1;
    end
  end
  always_ff @(posedge clk_i) begin
    last <= dev_true;
  end
  a_oe_pair: assert property (dev_true_oe == dev_inv_oe)
    else $error("line enables differ");
  a_inv_pair: assert property (dev_true_oe |-> dev_inv == ~dev_true)
    else $error("inverted line not inverse");
  a_no_collide: assert property (!(dev_true_oe && host_oe))
    else $error("both ends drive the line");
  a_hold_high: assert property ($fell(dev_true_oe)
    |-> last && run >= 4 * BIT)
    else $error("release without high hold");
  a_reply_baud: assert property (dev_true_oe && dev_true && !last
    && run != 0 |-> run % BIT == 0)
    else $error("reply bit time differs");
  a_dev_start: assert property ((dev_true_oe && $fell(dev_true))
    |-> (!dev_true) [*8])
    else $error("device start bit too short");
  a_host_start: assert property ((host_oe && $fell(host_tx))
    |-> (!host_tx) [*8])
    else $error("host start bit too short");
  a_host_stop: assert property ($fell(host_oe) |-> $past(host_tx))
    else $error("host released without stop bit");
endmodule

// File: single_wire_uart_slave_test.sv
// Bench for both link ends and a fault path into a second device
`timescale 1ns/1ps
module single_wire_uart_slave_test;
  localparam int B = 32;
  localparam int L = 300 * B;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic cmd_write_i = 1'b0;
  logic [6:0] cmd_addr_i = 7'h00;
  logic [31:0] cmd_wdata_i = 32'h0;
  logic [3:0] dly = 4'h1;
  logic [31:0] rdata = 32'h0;
  logic reg_wr, rx_err, busy, rd_valid, rd_error, wr_f, err_f;
  logic [6:0] reg_addr, addr_f;
  logic [31:0] reg_wdata, rd_data, wdata_f;
  logic [7:0] wcount, count_f;
  int fail_count = 0;
  int compares = 0;
  int mcount = 0;
  int nwf = 0;
  int nef = 0;
  logic [38:0] exp_q[$];

  always #2.5 clk_i = ~clk_i;

  swu_if swu_if_i ();
  swu_if swu_if_f_i ();
  swu_dev #(.BIT_DEF(B)) swu_dev_i (.clk_i(clk_i), .srst_i(srst_i),
    .link(swu_if_i), .reply_turnaround_delay_i(dly), .reg_rdata_i(rdata),
    .reg_wr_o(reg_wr), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .write_count_o(wcount), .rx_error_o(rx_err));
  swu_dev #(.BIT_DEF(B)) swu_dev_f_i (.clk_i(clk_i), .srst_i(srst_i),
    .link(swu_if_f_i), .reply_turnaround_delay_i(4'h1),
    .reg_rdata_i(32'h0), .reg_wr_o(wr_f), .reg_addr_o(addr_f),
    .reg_wdata_o(wdata_f), .write_count_o(count_f), .rx_error_o(err_f));
  swu_host #(.BIT_CYC(B)) swu_host_i (.clk_i(clk_i), .srst_i(srst_i),
    .link(swu_if_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
    .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .busy_o(busy),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .rd_error_o(rd_error));
  swu_link_checker #(.BIT(B)) swu_link_checker_i (.clk_i(clk_i),
    .srst_i(srst_i), .dev_true(swu_if_i.dev_true),
    .dev_true_oe(swu_if_i.dev_true_oe), .dev_inv(swu_if_i.dev_inv),
    .dev_inv_oe(swu_if_i.dev_inv_oe), .host_tx(swu_if_i.host_tx),
    .host_oe(swu_if_i.host_oe),
    .serial_line_true(swu_if_i.serial_line_true),
    .serial_line_inverted(swu_if_i.serial_line_inverted));

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tmo(logic ok);
    if (!ok) begin
      chk("wait", 1, 0);
      tally_and_finish();
    end
  endtask

  // Reference CRC8, poly 07, zero start, bits LSB first
  function automatic logic [7:0] crc(logic [7:0] c, logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[7] ^ b[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  always @(posedge clk_i) begin
    if (wr_f === 1'b1) nwf++;
    if (err_f === 1'b1) nef++;
    if (rx_err === 1'b1) chk("rx error", 0, 1);
    if (reg_wr === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spurious write", 0, 1);
      end else begin
        chk("wr addr", exp_q[0][38:32], reg_addr);
        chk("wr data", exp_q[0][31:0], reg_wdata);
        void'(exp_q.pop_front());
      end
    end
  end

  task automatic cmd(logic wr, logic [6:0] a, logic [31:0] d);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_write_i <= wr;
    cmd_addr_i <= a;
    cmd_wdata_i <= d;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
  endtask

  task automatic idle_wait();
    int n;
    @(posedge clk_i);
    for (n = 0; n < L && busy !== 1'b0; n++) @(posedge clk_i);
    tmo(busy === 1'b0);
    repeat (4) @(posedge clk_i);
    chk("write count", mcount[7:0], wcount);
  endtask

  // Receives one byte from the link, sampled mid bit
  task automatic rxb(output logic [7:0] b);
    int n;
    for (n = 0; n < L && swu_if_i.serial_line_true !== 1'b0; n++)
      @(posedge clk_i);
    tmo(swu_if_i.serial_line_true === 1'b0);
    repeat (B / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (B) @(posedge clk_i);
      b[i] = swu_if_i.serial_line_true;
    end
    repeat (B) @(posedge clk_i);
    chk("stop bit", 1, swu_if_i.serial_line_true);
  endtask

  task automatic do_read(logic [6:0] a, logic [3:0] d);
    int n;
    logic [7:0] b;
    logic [31:0] e;
    e = $urandom();
    rdata <= e;
    dly <= d;
    cmd(1'b0, a, 32'h0);
    for (n = 0; n < L && swu_if_i.host_oe !== 1'b1; n++) @(posedge clk_i);
    tmo(swu_if_i.host_oe === 1'b1);
    for (n = 0; n < L && swu_if_i.host_oe !== 1'b0; n++) @(posedge clk_i);
    tmo(swu_if_i.host_oe === 1'b0);
    for (n = 0; n < L && swu_if_i.dev_true_oe !== 1'b1; n++)
      @(posedge clk_i);
    tmo(swu_if_i.dev_true_oe === 1'b1);
    chk("turnaround", 1, n + B >= d * 8 * B &&
        n <= d * 8 * B + 2 * B);
    rxb(b);
    chk("reply sync", 8'h05, b);
    rxb(b);
    chk("reply addr", {1'b0, a}, b);
    for (n = 0; n < L && rd_valid !== 1'b1; n++) @(posedge clk_i);
    tmo(rd_valid === 1'b1);
    chk("rd data", e, rd_data);
    chk("rd error", 0, rd_error);
    idle_wait();
  endtask

  task automatic fbyte(logic [7:0] b, int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      swu_if_f_i.host_tx <= f[i];
      repeat (bt) @(posedge clk_i);
    end
  endtask

  task automatic fdgram(logic [6:0] a, logic [31:0] d, logic [7:0] x,
                        int bt);
    logic [47:0] m;
    logic [7:0] c;
    m = {8'h05, 1'b1, a, d};
    c = 8'h00;
    for (int i = 5; i >= 0; i--) begin
      c = crc(c, m[i*8+:8]);
      fbyte(m[i*8+:8], bt);
    end
    fbyte(c ^ x, bt);
    repeat (4 * bt) @(posedge clk_i);
  endtask

  initial begin
    logic [6:0] a;
    logic [31:0] d;
    logic [3:0] dl[3];
    swu_if_f_i.host_tx = 1'b1;
    swu_if_f_i.host_oe = 1'b1;
    dl = '{4'h1, 4'h2, 4'hF};
    void'($urandom(32'h16d4));
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      a = (k == 0) ? 7'h7F : (k == 1) ? 7'h00 : 7'($urandom());
      d = $urandom();
      exp_q.push_back({a, d});
      mcount++;
      cmd(1'b1, a, d);
      idle_wait();
      chk("write queue", 0, exp_q.size());
    end
    foreach (dl[k]) do_read(7'($urandom()), dl[k]);
    repeat (20 * B) @(posedge clk_i);
    swu_if_f_i.host_tx <= 1'b0;
    repeat (8) @(posedge clk_i);
    swu_if_f_i.host_tx <= 1'b1;
    repeat (20 * B) @(posedge clk_i);
    chk("glitch error", 1, nef);
    d = $urandom();
    fdgram(7'h2A, d, 8'h01, B);
    chk("bad crc error", 2, nef);
    chk("bad crc write", 0, nwf);
    repeat (14 * B) @(posedge clk_i);
    fdgram(7'h15, d, 8'h00, 48);
    chk("rebaud write", 1, nwf);
    chk("rebaud addr", 7'h15, addr_f);
    chk("rebaud data", d, wdata_f);
    chk("rebaud count", 1, count_f);
    repeat (14 * 48) @(posedge clk_i);
    fbyte(8'h05, 48);
    repeat (70 * 48) @(posedge clk_i);
    chk("gap error", 3, nef);
    tally_and_finish();
  end
endmodule
